// ---- shared/uhbt_pkg.sv ----
// Notes on behaviour
// RULE1 - Round-robin pick one going channel, then move on
// RULE2 - Bulk OUT waits for FIFO bytes and frame time
// RULE3 - OUT packet length is min(max_packet_len, total_len)
// RULE4 - OUT: token, data, then await handshake
// RULE5 - OUT ACK: ack flag, commit, release area
// RULE6 - OUT NAK: FIFO untouched, same transaction later
// RULE7 - OUT STALL: stop, STALL code, condition flag
// RULE8 - OUT no handshake: retry code, error flag, retry
// RULE9 - Third OUT failure stops transfer, condition flag
// RULE10 - Interrupt OUT also waits for token_interval
// RULE11 - Interrupt OUT handshakes handled like bulk OUT
// RULE12 - Bulk IN waits for FIFO space and frame time
// RULE13 - IN expects min(max_packet_len, total_len) bytes
// RULE14 - Endpoint returns one packet, takes handshake
// RULE15 - Full IN packet: ACK, ack flag, commit
// RULE16 - Short IN packet: ACK, commit, stop, short code
// RULE17 - IN NAK: no flag, FIFO unchanged
// RULE18 - IN STALL: stop, STALL code, condition flag
// RULE19 - IN overflow: no handshake, stop, overflow, discard
// RULE20 - IN toggle mismatch: ACK, discard, retry code
// RULE21 - IN bus errors: no handshake, discard, retry code
// RULE22 - Third IN failure stops transfer, condition flag
// RULE23 - Result codes are distinct local encodings
package uhbt_pkg;
  localparam int NCH_DEF = 4;
  localparam int LEN_W = 20;
  localparam int MPL_W = 11;
  localparam int IVL_W = 16;
  localparam int FIFO_W = 16;
  localparam int FT_W = 16;
  localparam int CH_SHIFT = 5;
  localparam logic [4:0] REG_CONFIG = 5'h00;
  localparam logic [4:0] REG_MAXPKT = 5'h04;
  localparam logic [4:0] REG_TOTAL = 5'h08;
  localparam logic [4:0] REG_INTERVAL = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam int CFG_GO_BIT = 0;
  localparam int CFG_IN_BIT = 1;
  localparam int CFG_INTR_BIT = 2;
  localparam int ST_ACK_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_CC_BIT = 2;
  localparam int ST_CODE_LSB = 8;
  localparam logic [MPL_W-1:0] MPL_RST = 11'h040;
  localparam logic [IVL_W-1:0] IVL_RST = 16'h0001;
  localparam logic [1:0] RETRY_LAST = 2'h2;
  // Token, handshake and gap time in byte units
  localparam logic [LEN_W:0] FRAME_OVH_BYTES = 21'h00010;
  typedef enum logic [2:0] {
    RC_NONE = 3'h0,
    RC_STALL = 3'h1,
    RC_RETRY_FAIL = 3'h2,
    RC_SHORT = 3'h3,
    RC_OVERFLOW = 3'h4
  } uhbt_rc_type;
  typedef enum logic [2:0] {
    SR_ACK = 3'h0,
    SR_NAK = 3'h1,
    SR_STALL = 3'h2,
    SR_DATA = 3'h3,
    SR_TOGGLE = 3'h4,
    SR_BAD = 3'h5
  } uhbt_sie_res_type;
  typedef enum logic [2:0] {
    S_PICK = 3'h0,
    S_JUDGE = 3'h1,
    S_TOKEN = 3'h2,
    S_WAIT = 3'h3
  } uhbt_state_type;
endpackage

// ---- shared/uhbt_judge_if.sv ----
interface uhbt_judge_if;
  import uhbt_pkg::*;
  logic go;
  logic is_in;
  logic is_intr;
  logic due;
  logic [MPL_W-1:0] mpl;
  logic [LEN_W-1:0] total;
  logic [FIFO_W-1:0] fifo_bytes;
  logic [FT_W-1:0] frame_left;
  logic [LEN_W-1:0] pkt_len;
  logic ok;
  modport sched (output go, is_in, is_intr, due, mpl, total, fifo_bytes, frame_left,
                 input pkt_len, ok);
  modport judge (input go, is_in, is_intr, due, mpl, total, fifo_bytes, frame_left,
                 output pkt_len, ok);
endinterface

// ---- logic/uhbt_judge.sv ----
module uhbt_judge
  import uhbt_pkg::*;
(
  uhbt_judge_if.judge j
);
  logic [LEN_W-1:0] mpl_ext;
  logic [LEN_W:0] need;
  logic fifo_ok;
  logic time_ok;

  assign mpl_ext = LEN_W'(j.mpl);
  assign j.pkt_len = (mpl_ext < j.total) ? mpl_ext : j.total; // [RULE3] [RULE13]
  // OUT needs stored bytes, IN needs free space
  assign fifo_ok = LEN_W'(j.fifo_bytes) >= j.pkt_len; // [RULE2] [RULE12]
  assign need = {1'b0, j.pkt_len} + FRAME_OVH_BYTES;
  assign time_ok = (LEN_W + 1)'(j.frame_left) >= need; // [RULE2] [RULE12]
  assign j.ok = j.go && fifo_ok && time_ok && (!j.is_intr || j.due); // [RULE10]
endmodule

// ---- logic/uhbt_interval.sv ----
module uhbt_interval
  import uhbt_pkg::*;
#(
  parameter int NCH = NCH_DEF
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Frame tick and issue
  input wire logic frame_tick,
  input wire logic issue,
  input wire logic [$clog2(NCH)-1:0] issue_ch,
  // Per channel
  input wire logic [IVL_W-1:0] interval [NCH],
  output logic due [NCH]
);
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      logic [IVL_W-1:0] cnt_ff;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cnt_ff <= '0;
        else if (issue && issue_ch == i)
          cnt_ff <= interval[i]; // [RULE10]
        else if (frame_tick && cnt_ff != '0)
          cnt_ff <= cnt_ff - 1'b1;
      end
      assign due[i] = (cnt_ff == '0);
    end
  endgenerate
endmodule

// ---- logic/uhbt_engine.sv ----
module uhbt_engine
  import uhbt_pkg::*;
#(
  parameter int NCH = NCH_DEF
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Frame timing
  input wire logic frame_tick,
  input wire logic [FT_W-1:0] frame_left,
  // FIFO occupancy per channel
  input wire logic [FIFO_W-1:0] fifo_valid_bytes [NCH],
  input wire logic [FIFO_W-1:0] fifo_free_bytes [NCH],
  // Token request to the SIE
  output logic tok_start,
  output logic tok_in,
  output logic [$clog2(NCH)-1:0] tok_ch,
  output logic [LEN_W-1:0] tok_len,
  // SIE result
  input wire logic sie_done,
  input wire logic [2:0] sie_result,
  input wire logic [LEN_W-1:0] rx_len,
  output logic hs_ack,
  // FIFO update
  output logic fifo_commit,
  output logic fifo_discard,
  output logic fifo_dir_in,
  output logic [$clog2(NCH)-1:0] fifo_ch,
  output logic [LEN_W-1:0] fifo_len
);
  localparam int CW = $clog2(NCH);

  function automatic logic [CW-1:0] ch_of(input logic [31:0] a);
    ch_of = a[CH_SHIFT +: CW];
  endfunction

  function automatic logic [4:0] reg_of(input logic [31:0] a);
    reg_of = a[4:0];
  endfunction

  uhbt_state_type state_ff;
  logic [CW-1:0] ch_ff;
  logic [LEN_W-1:0] pkt_len_ff;
  logic go_ff [NCH];
  logic in_ff [NCH];
  logic intr_ff [NCH];
  logic [MPL_W-1:0] mpl_ff [NCH];
  logic [LEN_W-1:0] total_ff [NCH];
  logic [IVL_W-1:0] ivl_ff [NCH];
  logic ack_ff [NCH];
  logic err_ff [NCH];
  logic cc_ff [NCH];
  uhbt_rc_type code_ff [NCH];
  logic [1:0] retry_ff [NCH];
  logic due [NCH];
  logic wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic tok_start_ff;
  logic tok_in_ff;
  logic [CW-1:0] tok_ch_ff;
  logic [LEN_W-1:0] tok_len_ff;
  logic hs_ack_ff;
  logic commit_ff;
  logic discard_ff;
  logic fdir_ff;
  logic [CW-1:0] fch_ff;
  logic [LEN_W-1:0] flen_ff;

  logic addr_ok;
  logic [31:0] nxt_rdata;
  logic [CW-1:0] wch;
  logic [4:0] wreg;
  logic ev;
  logic ev_ack;
  logic ev_fail;
  logic ev_cc;
  logic ev_clr_go;
  logic ev_commit;
  logic ev_discard;
  logic ev_hs;
  logic ev_code_we;
  uhbt_rc_type ev_code;
  logic [LEN_W-1:0] ev_len;
  logic [CW-1:0] nxt_ch;

  uhbt_judge_if jif ();

  assign jif.go = go_ff[ch_ff];
  assign jif.is_in = in_ff[ch_ff];
  assign jif.is_intr = intr_ff[ch_ff];
  assign jif.due = due[ch_ff];
  assign jif.mpl = mpl_ff[ch_ff];
  assign jif.total = total_ff[ch_ff];
  assign jif.fifo_bytes = in_ff[ch_ff] ? fifo_free_bytes[ch_ff] : fifo_valid_bytes[ch_ff];
  assign jif.frame_left = frame_left;

  uhbt_judge u_judge (
    .j(jif)
  );

  uhbt_interval #(.NCH(NCH)) u_interval (
    .hclk(hclk),
    .hresetn(hresetn),
    .frame_tick(frame_tick),
    .issue(tok_start_ff),
    .issue_ch(tok_ch_ff),
    .interval(ivl_ff),
    .due(due)
  );

  // Bus slave: zero wait states, always OKAY
  assign addr_ok = hsel && htrans[1] && hready;
  assign wch = ch_of(wr_addr_ff);
  assign wreg = reg_of(wr_addr_ff);

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (ch_of(haddr) < CW'(NCH - 1) || ch_of(haddr) == CW'(NCH - 1))
    begin
      unique case (reg_of(haddr))
        REG_CONFIG:
        begin
          nxt_rdata[CFG_GO_BIT] = go_ff[ch_of(haddr)];
          nxt_rdata[CFG_IN_BIT] = in_ff[ch_of(haddr)];
          nxt_rdata[CFG_INTR_BIT] = intr_ff[ch_of(haddr)];
        end
        REG_MAXPKT: nxt_rdata[MPL_W-1:0] = mpl_ff[ch_of(haddr)];
        REG_TOTAL: nxt_rdata[LEN_W-1:0] = total_ff[ch_of(haddr)];
        REG_INTERVAL: nxt_rdata[IVL_W-1:0] = ivl_ff[ch_of(haddr)];
        REG_STATUS:
        begin
          nxt_rdata[ST_ACK_BIT] = ack_ff[ch_of(haddr)];
          nxt_rdata[ST_ERR_BIT] = err_ff[ch_of(haddr)];
          nxt_rdata[ST_CC_BIT] = cc_ff[ch_of(haddr)];
          nxt_rdata[ST_CODE_LSB +: 3] = code_ff[ch_of(haddr)];
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
      hrdata_ff <= 32'h0000_0000;
      hready_ff <= 1'b1;
    end
    else
    begin
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_ff <= haddr;
      if (addr_ok && !hwrite)
        hrdata_ff <= nxt_rdata;
      hready_ff <= 1'b1;
    end
  end

  // Outcome of the finished transaction
  always_comb
  begin
    ev = (state_ff == S_WAIT) && sie_done;
    ev_ack = 1'b0;
    ev_fail = 1'b0;
    ev_cc = 1'b0;
    ev_clr_go = 1'b0;
    ev_commit = 1'b0;
    ev_discard = 1'b0;
    ev_hs = 1'b0;
    ev_code_we = 1'b0;
    ev_code = RC_NONE;
    ev_len = pkt_len_ff;
    if (ev && !in_ff[ch_ff])
    begin
      unique case (sie_result)
        SR_ACK:
        begin
          ev_ack = 1'b1; // [RULE5] [RULE11]
          ev_commit = 1'b1; // [RULE5]
        end
        SR_NAK: ev_ack = 1'b0; // [RULE6]
        SR_STALL:
        begin
          ev_clr_go = 1'b1; // [RULE7] [RULE11]
          ev_cc = 1'b1;
          ev_code_we = 1'b1;
          ev_code = RC_STALL;
        end
        default: ev_fail = 1'b1; // [RULE8]
      endcase
    end
    else if (ev)
    begin
      unique case (sie_result)
        SR_DATA:
        begin
          if (rx_len == pkt_len_ff)
          begin
            ev_hs = 1'b1; // [RULE15]
            ev_ack = 1'b1;
            ev_commit = 1'b1;
          end
          else if (rx_len < pkt_len_ff)
          begin
            ev_hs = 1'b1; // [RULE16]
            ev_commit = 1'b1;
            ev_len = rx_len;
            ev_clr_go = 1'b1;
            ev_cc = 1'b1;
            ev_code_we = 1'b1;
            ev_code = RC_SHORT;
          end
          else
          begin
            ev_discard = 1'b1; // [RULE19]
            ev_clr_go = 1'b1;
            ev_cc = 1'b1;
            ev_code_we = 1'b1;
            ev_code = RC_OVERFLOW;
          end
        end
        SR_NAK: ev_ack = 1'b0; // [RULE17]
        SR_STALL:
        begin
          ev_clr_go = 1'b1; // [RULE18]
          ev_cc = 1'b1;
          ev_code_we = 1'b1;
          ev_code = RC_STALL;
        end
        SR_TOGGLE:
        begin
          ev_hs = 1'b1; // [RULE20]
          ev_discard = 1'b1;
          ev_fail = 1'b1;
        end
        default:
        begin
          ev_discard = 1'b1; // [RULE21]
          ev_fail = 1'b1;
        end
      endcase
    end
    if (ev_fail)
    begin
      ev_code_we = 1'b1; // [RULE8] [RULE20] [RULE21]
      ev_code = RC_RETRY_FAIL; // [RULE23]
      if (retry_ff[ch_ff] == RETRY_LAST)
      begin
        ev_clr_go = 1'b1; // [RULE9] [RULE22]
        ev_cc = 1'b1;
      end
    end
    // Whole transfer moved: nothing left to schedule
    if (ev_commit && ev_len == total_ff[ch_ff])
      ev_clr_go = 1'b1;
  end

  assign nxt_ch = (ch_ff == CW'(NCH - 1)) ? '0 : ch_ff + 1'b1;

  // Scheduler: one transaction per visit, then the next channel
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= S_PICK;
      ch_ff <= '0;
      pkt_len_ff <= '0;
    end
    else
    begin
      unique case (state_ff)
        S_PICK:
        begin
          if (go_ff[ch_ff])
            state_ff <= S_JUDGE; // [RULE1]
          else
            ch_ff <= nxt_ch;
        end
        S_JUDGE:
        begin
          pkt_len_ff <= jif.pkt_len;
          if (jif.ok)
            state_ff <= S_TOKEN; // [RULE2] [RULE10] [RULE12]
          else
          begin
            state_ff <= S_PICK;
            ch_ff <= nxt_ch;
          end
        end
        S_TOKEN: state_ff <= S_WAIT; // [RULE4]
        S_WAIT:
        begin
          // Relies on the endpoint answering each token once
          if (sie_done)
          begin
            state_ff <= S_PICK; // [RULE1] [RULE14]
            ch_ff <= nxt_ch;
          end
        end
        default: state_ff <= S_PICK;
      endcase
    end
  end

  // Token and handshake strobes to the SIE
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tok_start_ff <= 1'b0;
      tok_in_ff <= 1'b0;
      tok_ch_ff <= '0;
      tok_len_ff <= '0;
      hs_ack_ff <= 1'b0;
    end
    else
    begin
      tok_start_ff <= (state_ff == S_TOKEN); // [RULE4]
      if (state_ff == S_TOKEN)
      begin
        tok_in_ff <= in_ff[ch_ff];
        tok_ch_ff <= ch_ff;
        tok_len_ff <= pkt_len_ff; // [RULE3] [RULE13]
      end
      hs_ack_ff <= ev_hs;
    end
  end

  // FIFO commit and discard strobes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      commit_ff <= 1'b0;
      discard_ff <= 1'b0;
      fdir_ff <= 1'b0;
      fch_ff <= '0;
      flen_ff <= '0;
    end
    else
    begin
      commit_ff <= ev_commit; // [RULE5] [RULE15] [RULE16]
      discard_ff <= ev_discard; // [RULE19] [RULE20] [RULE21]
      if (ev)
      begin
        fdir_ff <= in_ff[ch_ff];
        fch_ff <= ch_ff;
        flen_ff <= ev_len;
      end
    end
  end

  // Channel registers; hardware stop wins over a software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        go_ff[c] <= 1'b0;
        in_ff[c] <= 1'b0;
        intr_ff[c] <= 1'b0;
        mpl_ff[c] <= MPL_RST;
        ivl_ff[c] <= IVL_RST;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (ev_clr_go && ch_ff == CW'(c))
          go_ff[c] <= 1'b0; // [RULE7] [RULE9] [RULE16] [RULE18] [RULE19] [RULE22]
        else if (wr_pend_ff && wch == CW'(c) && wreg == REG_CONFIG)
          go_ff[c] <= hwdata[CFG_GO_BIT];
        if (wr_pend_ff && wch == CW'(c) && wreg == REG_CONFIG)
        begin
          in_ff[c] <= hwdata[CFG_IN_BIT];
          intr_ff[c] <= hwdata[CFG_INTR_BIT];
        end
        if (wr_pend_ff && wch == CW'(c) && wreg == REG_MAXPKT)
          mpl_ff[c] <= hwdata[MPL_W-1:0];
        if (wr_pend_ff && wch == CW'(c) && wreg == REG_INTERVAL)
          ivl_ff[c] <= hwdata[IVL_W-1:0];
      end
    end
  end

  // Remaining length shrinks by what was committed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < NCH; c++)
        total_ff[c] <= '0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (ev_commit && ch_ff == CW'(c))
          total_ff[c] <= total_ff[c] - ev_len;
        else if (wr_pend_ff && wch == CW'(c) && wreg == REG_TOTAL)
          total_ff[c] <= hwdata[LEN_W-1:0];
      end
    end
  end

  // Sticky flags: write one to clear, a new event wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        ack_ff[c] <= 1'b0;
        err_ff[c] <= 1'b0;
        cc_ff[c] <= 1'b0;
        code_ff[c] <= RC_NONE;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (ev_code_we && ch_ff == CW'(c))
          code_ff[c] <= ev_code; // [RULE23]
        if (wr_pend_ff && wch == CW'(c) && wreg == REG_STATUS)
        begin
          ack_ff[c] <= ack_ff[c] && !hwdata[ST_ACK_BIT];
          err_ff[c] <= err_ff[c] && !hwdata[ST_ERR_BIT];
          cc_ff[c] <= cc_ff[c] && !hwdata[ST_CC_BIT];
        end
        if (ev_ack && ch_ff == CW'(c))
          ack_ff[c] <= 1'b1; // [RULE5] [RULE15]
        if (ev_fail && ch_ff == CW'(c))
          err_ff[c] <= 1'b1; // [RULE8] [RULE20] [RULE21]
        if (ev_cc && ch_ff == CW'(c))
          cc_ff[c] <= 1'b1; // [RULE7] [RULE9] [RULE18] [RULE22]
      end
    end
  end

  // Consecutive failure count; NAK leaves it alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < NCH; c++)
        retry_ff[c] <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (ev_fail && ch_ff == CW'(c))
          retry_ff[c] <= (retry_ff[c] == RETRY_LAST) ? 2'h0 : retry_ff[c] + 2'h1; // [RULE22]
        else if ((ev_commit || ev_clr_go) && ch_ff == CW'(c))
          retry_ff[c] <= 2'h0;
        else if (wr_pend_ff && wch == CW'(c) && wreg == REG_CONFIG)
          retry_ff[c] <= 2'h0;
      end
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign tok_start = tok_start_ff;
  assign tok_in = tok_in_ff;
  assign tok_ch = tok_ch_ff;
  assign tok_len = tok_len_ff;
  assign hs_ack = hs_ack_ff;
  assign fifo_commit = commit_ff;
  assign fifo_discard = discard_ff;
  assign fifo_dir_in = fdir_ff;
  assign fifo_ch = fch_ff;
  assign fifo_len = flen_ff;
endmodule

// ---- verification/uhbt_ep_model.sv ----
module uhbt_ep_model
  import uhbt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Token from the engine
  input wire logic tok_start,
  // Planned answer
  input wire logic [2:0] res,
  input wire logic [LEN_W-1:0] rx,
  input wire logic [3:0] dly,
  // Outcome to the engine
  output logic sie_done,
  output logic [2:0] sie_result,
  output logic [LEN_W-1:0] rx_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_ff;
  logic [3:0] cnt_ff;
  // Outside the answer cycle the result lines keep changing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      sie_done <= 1'b0;
      sie_result <= 3'h0;
      rx_len <= '0;
    end
    else
    begin
      sie_done <= 1'b0;
      sie_result <= ~sie_result;
      rx_len <= ~rx_len;
      if (tok_start)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= dly;
      end
      else if (busy_ff && cnt_ff == 4'h0)
      begin
        busy_ff <= 1'b0;
        sie_done <= 1'b1;
        sie_result <= res;
        rx_len <= rx;
      end
      else if (busy_ff)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule

// ---- verification/uhbt_chk.sv ----
module uhbt_chk
  import uhbt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Token and outcome
  input wire logic tok_start,
  input wire logic tok_in,
  input wire logic [LEN_W-1:0] tok_len,
  input wire logic sie_done,
  input wire logic [2:0] sie_result,
  input wire logic [LEN_W-1:0] rx_len,
  // Handshake and FIFO update
  input wire logic hs_ack,
  input wire logic fifo_commit,
  input wire logic fifo_discard,
  input wire logic fifo_dir_in,
  input wire logic [LEN_W-1:0] fifo_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wait_ff, fin, din;
  // Outcomes outside a transaction are ignored by the engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wait_ff <= 1'b0;
    else if (tok_start)
      wait_ff <= 1'b1;
    else if (sie_done)
      wait_ff <= 1'b0;
  end
  assign fin = wait_ff && sie_done;
  assign din = fin && tok_in && sie_result == SR_DATA;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_one_outstanding: assert property (tok_start |-> !wait_ff) else $error("busy token");
  a_out_ack_commit: assert property (fin && !tok_in && sie_result == SR_ACK |=>
    fifo_commit && !fifo_dir_in && fifo_len == $past(tok_len) && !hs_ack) else $error("out ack");
  a_nak_quiet: assert property (fin && sie_result == SR_NAK |=>
    !fifo_commit && !fifo_discard && !hs_ack) else $error("nak update");
  a_stall_quiet: assert property (fin && sie_result == SR_STALL |=>
    !fifo_commit && !hs_ack) else $error("stall update");
  a_in_full: assert property (din && rx_len == tok_len |=> hs_ack && fifo_commit
    && fifo_dir_in && fifo_len == $past(rx_len)) else $error("in full");
  a_in_short: assert property (din && rx_len < tok_len |=> hs_ack && fifo_commit
    && fifo_len == $past(rx_len)) else $error("in short");
  a_in_over: assert property (din && rx_len > tok_len |=> !hs_ack && !fifo_commit
    && fifo_discard) else $error("in overflow");
  a_toggle_ack: assert property (fin && tok_in && sie_result == SR_TOGGLE |=>
    hs_ack && !fifo_commit && fifo_discard) else $error("toggle");
  a_bad_silent: assert property (fin && sie_result >= SR_BAD |=>
    !hs_ack && !fifo_commit) else $error("bad answer");
endmodule
bind uhbt_engine uhbt_chk uhbt_chk_i (.hclk(hclk), .hresetn(hresetn), .tok_start(tok_start),
  .tok_in(tok_in), .tok_len(tok_len), .sie_done(sie_done), .sie_result(sie_result),
  .rx_len(rx_len), .hs_ack(hs_ack), .fifo_commit(fifo_commit), .fifo_discard(fifo_discard),
  .fifo_dir_in(fifo_dir_in), .fifo_len(fifo_len));

// ---- verification/testbench.sv ----
module testbench
  import uhbt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [1:0] ty;
    logic [10:0] mpl;
    logic [19:0] tot;
    logic [2:0] res;
    logic [19:0] rx;
    int n;
    logic [31:0] st, msk;
    logic go;
  } uhbt_tb_row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, frame_tick = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, sie_result, m_res = 3'h0;
  logic hreadyout, hresp, tok_start, tok_in, sie_done, hs_ack;
  logic fifo_commit, fifo_discard, fifo_dir_in;
  logic [0:0] tok_ch, fifo_ch, ch_a, ch_b;
  logic [LEN_W-1:0] tok_len, rx_len, fifo_len, m_rx = 20'h0;
  logic [FT_W-1:0] frame_left = 16'hffff;
  logic [FIFO_W-1:0] fifo_valid_bytes [2] = '{16'hffff, 16'hffff};
  logic [FIFO_W-1:0] fifo_free_bytes [2] = '{16'hffff, 16'hffff};
  logic [3:0] m_dly = 4'h1;
  int bad_count = 0, n_checks = 0, n_tok = 0, n_done = 0, fc = 0;
  uhbt_tb_row_type rows [14] = '{
    '{2'h0, 11'h008, 20'h00014, SR_NAK, 20'h0, 2, 32'h0, 32'h7, 1'b1},
    '{2'h1, 11'h008, 20'h00014, SR_NAK, 20'h0, 2, 32'h0, 32'h7, 1'b1},
    '{2'h0, 11'h008, 20'h00005, SR_ACK, 20'h0, 1, 32'h1, 32'h7, 1'b0},
    '{2'h0, 11'h008, 20'h00014, SR_STALL, 20'h0, 1, 32'h104, 32'h707, 1'b0},
    '{2'h0, 11'h008, 20'h00014, SR_BAD, 20'h0, 3, 32'h206, 32'h707, 1'b0},
    '{2'h2, 11'h004, 20'h00004, SR_ACK, 20'h0, 1, 32'h1, 32'h7, 1'b0},
    '{2'h2, 11'h004, 20'h00014, SR_STALL, 20'h0, 1, 32'h104, 32'h707, 1'b0},
    '{2'h2, 11'h004, 20'h00014, SR_BAD, 20'h0, 3, 32'h206, 32'h707, 1'b0},
    '{2'h1, 11'h008, 20'h00008, SR_DATA, 20'h8, 1, 32'h1, 32'h7, 1'b0},
    '{2'h1, 11'h008, 20'h00014, SR_DATA, 20'h3, 1, 32'h304, 32'h707, 1'b0},
    '{2'h1, 11'h008, 20'h00014, SR_DATA, 20'h9, 1, 32'h404, 32'h707, 1'b0},
    '{2'h1, 11'h008, 20'h00014, SR_STALL, 20'h0, 1, 32'h104, 32'h707, 1'b0},
    '{2'h1, 11'h008, 20'h00014, SR_TOGGLE, 20'h0, 3, 32'h206, 32'h707, 1'b0},
    '{2'h1, 11'h008, 20'h00014, SR_BAD, 20'h0, 3, 32'h206, 32'h707, 1'b0}};
  always #5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    fc <= fc + 1;
    frame_tick <= (fc % 50 == 0);
    if (tok_start === 1'b1)
    begin
      n_tok <= n_tok + 1;
      ch_a <= tok_ch;
      ch_b <= ch_a;
    end
    if (sie_done === 1'b1)
      n_done <= n_done + 1;
  end
  uhbt_engine #(.NCH(2)) uhbt_engine_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_tick(frame_tick), .frame_left(frame_left), .fifo_valid_bytes(fifo_valid_bytes),
    .fifo_free_bytes(fifo_free_bytes), .tok_start(tok_start), .tok_in(tok_in),
    .tok_ch(tok_ch), .tok_len(tok_len), .sie_done(sie_done), .sie_result(sie_result),
    .rx_len(rx_len), .hs_ack(hs_ack), .fifo_commit(fifo_commit),
    .fifo_discard(fifo_discard), .fifo_dir_in(fifo_dir_in), .fifo_ch(fifo_ch),
    .fifo_len(fifo_len));
  uhbt_ep_model uhbt_ep_model_i (.hclk(hclk), .hresetn(hresetn), .tok_start(tok_start),
    .res(m_res), .rx(m_rx), .dly(m_dly), .sie_done(sie_done), .sie_result(sie_result),
    .rx_len(rx_len));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic to(input int i);
    if (i >= 400)
    begin
      bad_count++;
      $display("timeout at %0t", $time);
      conclude();
    end
  endtask
  task automatic wait_cnt(ref int c, input int n);
    int i;
    for (i = 0; c < n && i < 400; i++)
      @(posedge hclk);
    to(i);
  endtask
  task automatic ready_edge();
    int i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 400);
    to(i);
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  function automatic logic [31:0] adr(input int ch, input logic [4:0] off);
    return 32'(ch << CH_SHIFT) | {27'h0, off};
  endfunction
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic reset_reads();
    rdc(adr(1, REG_CONFIG), 32'h0);
    rdc(adr(0, REG_MAXPKT), 32'h40);
    rdc(adr(0, REG_INTERVAL), 32'h1);
    rdc(adr(0, REG_STATUS), 32'h0);
    rdc(adr(0, 5'h14), 32'h0);
    $display("test reset values done");
  endtask
  initial
  begin
    uhbt_tb_row_type r;
    int t0, d0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    reset_reads();
    foreach (rows[k])
    begin
      r = rows[k];
      m_res <= r.res;
      m_rx <= r.rx;
      m_dly <= (k % 2) ? 4'h6 : 4'h1;
      bus(1'b1, adr(0, REG_MAXPKT), {21'h0, r.mpl});
      bus(1'b1, adr(0, REG_TOTAL), {12'h0, r.tot});
      t0 = n_tok;
      d0 = n_done;
      bus(1'b1, adr(0, REG_CONFIG), {29'h0, r.ty, 1'b1});
      wait_cnt(n_tok, t0 + 1);
      chk(tok_len, (r.mpl < r.tot) ? {9'h0, r.mpl} : r.tot);
      chk(tok_in, r.ty[0]);
      wait_cnt(n_done, d0 + r.n);
      bus(1'b0, adr(0, REG_STATUS), 32'h0);
      chk(rd & r.msk, r.st);
      rdc(adr(0, REG_CONFIG), {29'h0, r.ty, r.go});
      bus(1'b1, adr(0, REG_CONFIG), 32'h0);
      repeat (12) @(posedge hclk);
      bus(1'b1, adr(0, REG_STATUS), 32'h7);
      $display("test row %0d done", k);
    end
    // Judge must hold the token while the FIFO cannot serve it
    for (int j = 0; j < 2; j++)
    begin
      fifo_valid_bytes[0] <= j ? 16'hffff : 16'h0004;
      fifo_free_bytes[0] <= j ? 16'h0004 : 16'hffff;
      m_res <= j ? SR_DATA : SR_ACK;
      m_rx <= 20'h8;
      bus(1'b1, adr(0, REG_TOTAL), 32'h8);
      t0 = n_tok;
      d0 = n_done;
      bus(1'b1, adr(0, REG_CONFIG), {30'h0, j == 1, 1'b1});
      repeat (30) @(posedge hclk);
      chk(n_tok, t0);
      fifo_valid_bytes[0] <= 16'hffff;
      fifo_free_bytes[0] <= 16'hffff;
      wait_cnt(n_done, d0 + 1);
      rdc(adr(0, REG_CONFIG), {30'h0, j == 1, 1'b0});
      bus(1'b1, adr(0, REG_STATUS), 32'h7);
      $display("test fifo hold %0d done", j);
    end
    m_res <= SR_NAK;
    bus(1'b1, adr(0, REG_TOTAL), 32'h14);
    bus(1'b1, adr(1, REG_TOTAL), 32'h14);
    t0 = n_tok;
    bus(1'b1, adr(0, REG_CONFIG), 32'h1);
    bus(1'b1, adr(1, REG_CONFIG), 32'h1);
    wait_cnt(n_tok, t0 + 2);
    chk(ch_a ^ ch_b, 1'b1);
    chk(fifo_ch, ch_b);
    $display("test channel rotation done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    reset_reads();
    conclude();
  end
endmodule
